// ===== flash_seq_pkg.sv
// constants for the flash command sequencer host controller
// assumes a 25 MHz bus clock and a word-mode flash on the far side
package flash_seq_pkg;
    // clock and timing
    localparam int CLK_MHZ     = 25;
    localparam int COLLECT_US  = 50;
    localparam int COLLECT_CYC = COLLECT_US * CLK_MHZ;              // longest time, rounds down
    localparam int WE_LOW_NS   = 80;
    localparam int WE_CYC      = (WE_LOW_NS * CLK_MHZ + 999) / 1000; // least time, rounds up
    localparam int RD_NS       = 80;
    localparam int RD_CYC      = (RD_NS * CLK_MHZ + 999) / 1000;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;

    // reset values
    localparam logic [18:0] ADDR_RST = 19'h00000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // status field positions
    localparam int ST_BUSY   = 0;
    localparam int ST_BYPASS = 1;
    localparam int ST_ERASE  = 2;
    localparam int ST_SUSP   = 3;
    localparam int ST_WINDOW = 4;
    localparam int ST_CHIP   = 5;
    localparam int ST_ERR    = 6;
    localparam int ST_TIMER  = 7;
    localparam int ST_POLL   = 8;
    localparam int ST_TOGGLE = 9;
    localparam int ST_TOG2   = 10;
    localparam int ST_RDYBSY = 11;

    // operation codes written to the control register
    localparam logic [3:0] OP_BYP_EN   = 4'h1;
    localparam logic [3:0] OP_BPROG    = 4'h2;
    localparam logic [3:0] OP_BYP_EXIT = 4'h3;
    localparam logic [3:0] OP_CHIP     = 4'h4;
    localparam logic [3:0] OP_SECT     = 4'h5;
    localparam logic [3:0] OP_ADD_SECT = 4'h6;
    localparam logic [3:0] OP_SUSP     = 4'h7;
    localparam logic [3:0] OP_RESUME   = 4'h8;
    localparam logic [3:0] OP_READ     = 4'h9;

    // flash command words and addresses
    localparam logic [18:0] ADDR_UNLK1  = 19'h00555;
    localparam logic [18:0] ADDR_UNLK2  = 19'h002aa;
    localparam logic [18:0] ADDR_DC     = 19'h00000;
    localparam logic [15:0] CMD_UNLK1   = 16'h00aa;
    localparam logic [15:0] CMD_UNLK2   = 16'h0055;
    localparam logic [15:0] CMD_BYPASS  = 16'h0020;
    localparam logic [15:0] CMD_PROG    = 16'h00a0;
    localparam logic [15:0] CMD_BEXIT1  = 16'h0090;
    localparam logic [15:0] CMD_BEXIT2  = 16'h0000;
    localparam logic [15:0] CMD_SETUP   = 16'h0080;
    localparam logic [15:0] CMD_CHIP    = 16'h0010;
    localparam logic [15:0] CMD_SECT    = 16'h0030;
    localparam logic [15:0] CMD_SUSP    = 16'h00b0;
    localparam logic [15:0] CMD_RESUME  = 16'h0030;
    localparam int          SECT_LSB    = 12;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SETUP = 3'b001,
        S_WLOW  = 3'b010,
        S_WHIGH = 3'b011,
        S_RLOW  = 3'b100
    } seq_e;
endpackage

// ===== flash_seq_host.sv
// host controller issuing bypass, erase, suspend and resume sequences to a NOR flash
// assumes an AHB-Lite master on one side and the flash pins, synchronous to hclk, on the other
`timescale 1ns/1ns
module flash_seq_host
    import flash_seq_pkg::*;
(
    input  wire logic        hclk,         // bus clock
    input  wire logic        hresetn,      // async reset, active low
    input  wire logic        hsel,         // slave select
    input  wire logic [31:0] haddr,        // byte address
    input  wire logic [1:0]  htrans,       // transfer type
    input  wire logic        hwrite,       // write when high
    input  wire logic [2:0]  hsize,        // word only
    input  wire logic [31:0] hwdata,       // write data
    input  wire logic        hready,       // bus ready
    output logic             hreadyout,    // always ready
    output logic             hresp,        // always okay
    output logic      [31:0] hrdata,       // read data
    output logic      [18:0] f_addr,       // flash address
    output logic      [15:0] f_dq_out,     // flash data out
    output logic             f_dq_oe,      // drive data pins when high
    input  wire logic [15:0] f_dq_in,      // flash data in
    output logic             f_ce_n,       // chip enable, active low
    output logic             f_we_n,       // write enable, active low
    output logic             f_oe_n,       // output enable, active low
    input  wire logic        ready_busy_n  // flash ready/busy
);
    seq_e        state_r;
    logic [3:0]  op_r;
    logic [2:0]  idx_r;
    logic [2:0]  cnt_r;
    logic [18:0] addr_r;
    logic [15:0] data_r;
    logic [15:0] rdata_r;
    logic [18:0] f_addr_r;
    logic [15:0] f_dq_r;
    logic        bypass_r;
    logic        chip_act_r;
    logic        erase_act_r;
    logic        susp_r;
    logic        err_r;
    logic        rb_q_r;
    logic [10:0] win_cnt_r;
    logic        dph_wr_r;
    logic [7:0]  dph_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] status;

    // one command word per step of each operation
    function automatic logic [34:0] step_val(input logic [3:0] op, input logic [2:0] idx,
                                             input logic [18:0] a, input logic [15:0] d);
        logic [18:0] sa;
        sa = {a[18:SECT_LSB], 12'h000};
        case (op)
            OP_BYP_EN: begin
                if (idx == 3'd0) step_val = {ADDR_UNLK1, CMD_UNLK1};
                else if (idx == 3'd1) step_val = {ADDR_UNLK2, CMD_UNLK2};
                else step_val = {ADDR_UNLK1, CMD_BYPASS};
            end
            OP_BPROG:    step_val = (idx == 3'd0) ? {ADDR_DC, CMD_PROG} : {a, d};
            OP_BYP_EXIT: step_val = (idx == 3'd0) ? {ADDR_DC, CMD_BEXIT1}
                                                  : {ADDR_DC, CMD_BEXIT2};
            OP_CHIP, OP_SECT: begin
                case (idx)
                    3'd0, 3'd3: step_val = {ADDR_UNLK1, CMD_UNLK1};
                    3'd1, 3'd4: step_val = {ADDR_UNLK2, CMD_UNLK2};
                    3'd2:       step_val = {ADDR_UNLK1, CMD_SETUP};
                    default:    step_val = (op == OP_CHIP) ? {ADDR_UNLK1, CMD_CHIP}
                                                           : {sa, CMD_SECT};
                endcase
            end
            OP_ADD_SECT: step_val = {sa, CMD_SECT};
            OP_SUSP:     step_val = {ADDR_DC, CMD_SUSP};
            OP_RESUME:   step_val = {ADDR_DC, CMD_RESUME};
            default:     step_val = {a, 16'h0000};
        endcase
    endfunction

    // number of bus cycles per operation
    function automatic logic [2:0] n_steps(input logic [3:0] op);
        case (op)
            OP_BYP_EN:            n_steps = 3'd3;
            OP_BPROG, OP_BYP_EXIT: n_steps = 3'd2;
            OP_CHIP, OP_SECT:     n_steps = 3'd6;
            default:              n_steps = 3'd1;
        endcase
    endfunction

    // bus slave decode
    wire        a_phase  = hsel & hready & htrans[1];
    wire        wr_ctrl  = dph_wr_r & (dph_addr_r == REG_CTRL);
    wire        wr_addr  = dph_wr_r & (dph_addr_r == REG_ADDR);
    wire        wr_data  = dph_wr_r & (dph_addr_r == REG_DATA);
    wire        wr_stat  = dph_wr_r & (dph_addr_r == REG_STATUS);
    wire [3:0]  op_req   = hwdata[3:0];
    wire        idle     = (state_r == S_IDLE);
    wire        win_open = (win_cnt_r != 11'd0);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // which operations the current flash mode admits
    wire ok_read  = (op_req == OP_READ);
    wire ok_chip  = ok_read;
    wire ok_byp   = ok_read | (op_req == OP_BPROG) | (op_req == OP_BYP_EXIT);
    wire ok_susp  = ok_read | (op_req == OP_RESUME);
    wire ok_win   = ok_read | (op_req == OP_ADD_SECT) | (op_req == OP_SUSP);
    wire ok_erase = ok_read | (op_req == OP_SUSP);
    wire ok_base  = ok_read | (op_req == OP_BYP_EN) | (op_req == OP_CHIP) |
                    (op_req == OP_SECT);
    wire legal    = chip_act_r ? ok_chip : bypass_r ? ok_byp : susp_r ? ok_susp :
                    win_open ? ok_win : erase_act_r ? ok_erase : ok_base;
    wire start    = wr_ctrl & idle & legal;
    wire refuse   = wr_ctrl & ~start;

    // sequencer step control
    wire [2:0]  last_idx  = n_steps(op_r) - 3'd1;
    wire        step_end  = (state_r == S_WHIGH);
    wire        op_done   = (step_end & (idx_r == last_idx)) |
                            ((state_r == S_RLOW) & (cnt_r == 3'd0));
    wire [2:0]  idx_nxt   = start ? 3'd0 : 3'(idx_r + 3'd1);
    wire [3:0]  op_nxt    = start ? op_req : op_r;
    wire [34:0] step_nxt  = step_val(op_nxt, idx_nxt, addr_r, data_r);
    wire        load_pins = start | (step_end & ~op_done);
    wire        rb_rise   = ready_busy_n & ~rb_q_r;
    wire        erase_end = rb_rise & ~susp_r & ~win_open & idle;

    // pin strobes decoded from the sequencer state
    assign f_ce_n   = idle;
    assign f_we_n   = (state_r != S_WLOW);
    assign f_oe_n   = (state_r != S_RLOW);
    assign f_dq_oe  = ~idle & (op_r != OP_READ);
    assign f_addr   = f_addr_r;
    assign f_dq_out = f_dq_r;

    // sequencer state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            cnt_r   <= 3'd0;
        end else begin
            case (state_r)
                S_IDLE:  if (start) state_r <= S_SETUP;
                S_SETUP: begin
                    state_r <= (op_r == OP_READ) ? S_RLOW : S_WLOW;
                    cnt_r   <= (op_r == OP_READ) ? 3'(RD_CYC - 1) : 3'(WE_CYC - 1);
                end
                S_WLOW:  if (cnt_r == 3'd0) state_r <= S_WHIGH; else cnt_r <= cnt_r - 3'd1;
                S_WHIGH: state_r <= op_done ? S_IDLE : S_SETUP;
                S_RLOW:  if (cnt_r == 3'd0) state_r <= S_IDLE; else cnt_r <= cnt_r - 3'd1;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // operation, step index and pin values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_r     <= OP_READ;
            idx_r    <= 3'd0;
            f_addr_r <= ADDR_RST;
            f_dq_r   <= DATA_RST;
        end else if (load_pins) begin
            op_r     <= op_nxt;
            idx_r    <= idx_nxt;
            f_addr_r <= step_nxt[34:16];
            f_dq_r   <= step_nxt[15:0];
        end
    end

    // flash mode tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bypass_r    <= 1'b0;
            chip_act_r  <= 1'b0;
            erase_act_r <= 1'b0;
            susp_r      <= 1'b0;
            win_cnt_r   <= 11'd0;
            rb_q_r      <= 1'b1;
        end else begin
            rb_q_r <= ready_busy_n;
            if (op_done && (op_r == OP_BYP_EN)) bypass_r <= 1'b1;
            if (op_done && (op_r == OP_BYP_EXIT)) bypass_r <= 1'b0;
            if (op_done && (op_r == OP_CHIP)) chip_act_r <= 1'b1;
            else if (erase_end) chip_act_r <= 1'b0;
            if (op_done && ((op_r == OP_SECT) || (op_r == OP_ADD_SECT))) begin
                erase_act_r <= 1'b1;
                win_cnt_r   <= 11'(COLLECT_CYC - 1);
            end else if (op_done && (op_r == OP_SUSP)) begin
                win_cnt_r   <= 11'd0;
            end else if (win_open) begin
                win_cnt_r   <= win_cnt_r - 11'd1;
            end else if (erase_end) begin
                erase_act_r <= 1'b0;
            end
            if (op_done && (op_r == OP_SUSP)) susp_r <= 1'b1;
            if (op_done && (op_r == OP_RESUME)) susp_r <= 1'b0;
        end
    end

    // software registers, read capture and refusal flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r  <= ADDR_RST;
            data_r  <= DATA_RST;
            rdata_r <= DATA_RST;
            err_r   <= 1'b0;
        end else begin
            if (wr_addr) addr_r <= hwdata[18:0];
            if (wr_data) data_r <= hwdata[15:0];
            if (op_done && (op_r == OP_READ)) rdata_r <= f_dq_in;
            if (refuse) err_r <= 1'b1;
            else if (wr_stat && hwdata[ST_ERR]) err_r <= 1'b0;
        end
    end

    // status word
    always_comb begin
        status            = 32'h00000000;
        status[ST_BUSY]   = ~idle;
        status[ST_BYPASS] = bypass_r;
        status[ST_ERASE]  = erase_act_r;
        status[ST_SUSP]   = susp_r;
        status[ST_WINDOW] = win_open;
        status[ST_CHIP]   = chip_act_r;
        status[ST_ERR]    = err_r;
        status[ST_TIMER]  = rdata_r[3];
        status[ST_POLL]   = rdata_r[7];
        status[ST_TOGGLE] = rdata_r[6];
        status[ST_TOG2]   = rdata_r[2];
        status[ST_RDYBSY] = ready_busy_n;
    end

    // bus address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata_r   <= 32'h00000000;
        end else begin
            dph_wr_r   <= a_phase & hwrite;
            dph_addr_r <= haddr[7:0];
            if (a_phase && !hwrite) begin
                case (haddr[7:0])
                    REG_CTRL:   hrdata_r <= {28'h0000000, op_r};
                    REG_ADDR:   hrdata_r <= {13'h0000, addr_r};
                    REG_DATA:   hrdata_r <= {16'h0000, data_r};
                    REG_STATUS: hrdata_r <= status;
                    REG_RDATA:  hrdata_r <= {16'h0000, rdata_r};
                    default:    hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_we_pulse_width: assert property ($fell(f_we_n) |-> !f_we_n ##1 !f_we_n ##1 f_we_n)
        else $error("write pulse width wrong");
    a_unlock_first: assert property (!f_we_n && idx_r == 3'd0 && (op_r == OP_BYP_EN ||
        op_r == OP_CHIP || op_r == OP_SECT) |-> f_addr == ADDR_UNLK1 && f_dq_out == CMD_UNLK1)
        else $error("first unlock cycle wrong");
    a_bypass_entry: assert property ($rose(bypass_r) |-> $past(op_r) == OP_BYP_EN)
        else $error("bypass set without entry sequence");
    a_bypass_prog_gate: assert property (!f_we_n && op_r == OP_BPROG |-> bypass_r)
        else $error("bypass program outside bypass mode");
    a_chip_quiet: assert property (chip_act_r |-> f_we_n)
        else $error("write during chip erase");
    a_sector_bits: assert property (!f_we_n && f_dq_out == CMD_SECT &&
        (op_r == OP_SECT || op_r == OP_ADD_SECT)
        |-> f_addr[11:0] == 12'h000)
        else $error("sector address low bits set");
    a_window_open: assert property ($rose(win_open) |->
        win_cnt_r == 11'(COLLECT_CYC - 1) ##0 win_open [*8])
        else $error("collection window closed early");
    a_suspend_gate: assert property ($rose(susp_r) |-> $past(erase_act_r) && !chip_act_r)
        else $error("suspend outside sector erase");
    a_suspend_close: assert property ($rose(susp_r) |-> !win_open)
        else $error("window still open after suspend");
    a_resume_only: assert property ($fell(susp_r) |-> $past(op_r) == OP_RESUME)
        else $error("suspend left without resume");
    a_refuse_flag: assert property (refuse |=> err_r)
        else $error("refused command not flagged");

    c_bypass_prog: cover property (op_done && op_r == OP_BPROG);
    c_add_sector:  cover property (op_done && op_r == OP_ADD_SECT);
    c_suspend:     cover property ($rose(susp_r));
    c_chip_done:   cover property ($fell(chip_act_r));
endmodule

// ===== flash_dev_model.sv
// word-mode flash command machine standing on the far side of the host
// assumes pins move on the host clock; a write is taken when we_n rises
`timescale 1ns/1ns
module flash_dev_model #(
    parameter int ERASE_CYC = 2000, // erase length
    parameter int SUSP_CYC  = 40,   // suspend latency, under 500
    parameter int WIN_CYC   = 1250  // collection time-out
) (
    input  wire logic        clk,   // host clock
    input  wire logic        rst_n, // power-up reset
    input  wire logic [18:0] addr,  // address pins
    input  wire logic [15:0] dq_wr, // data from host
    input  wire logic        ce_n,  // chip enable
    input  wire logic        we_n,  // write enable
    input  wire logic        oe_n,  // output enable
    output logic      [15:0] dq_rd, // data to host
    output logic             rdy    // low while busy
);
    logic [10:0]  ha[6];
    logic [7:0]   hd[6];
    logic [15:0]  mem[int];
    logic [127:0] sel;
    logic         we_q, oe_q, byp, pgm, chip, susp, tmo, tgl, bsy;
    int           win, ers, spend;
    // first five cycles of a six-cycle erase command
    function automatic logic six();
        return ha[5] == 11'h555 && hd[5] == 8'haa && hd[4] == 8'h55 && hd[3] == 8'h80
            && ha[2] == 11'h555 && hd[2] == 8'haa && hd[1] == 8'h55;
    endfunction
    // timers, command decode and read data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {byp, pgm, chip, susp, tmo, tgl, win, ers, spend} = '0;
            {we_q, oe_q} = 2'b11;
            sel = '0;
            hd = '{default: 8'h00};
            ha = '{default: 11'h000};
            rdy <= 1'b1;
            dq_rd <= 16'h0000;
        end else begin
            if (win > 0 && --win == 0) begin
                tmo = 1'b1;
                ers = ERASE_CYC;
            end
            if (spend > 0 && --spend == 0)
                susp = 1'b1;
            if (ers > 0 && !susp && spend == 0 && --ers == 0) begin
                chip = 1'b0;
                sel = '0;
            end
            if (!ce_n && we_n && !we_q) begin
                for (int i = 5; i > 0; i--) begin
                    ha[i] = ha[i-1];
                    hd[i] = hd[i-1];
                end
                ha[0] = addr[10:0];
                hd[0] = dq_wr[7:0];
                if (chip)
                    ;
                else if (win > 0) begin
                    if (hd[0] == 8'h30) begin
                        win = WIN_CYC;
                        sel[addr[18:12]] = 1'b1;
                    end else if (hd[0] == 8'hb0) begin
                        win = 0;
                        susp = 1'b1;
                        ers = ERASE_CYC;
                    end else begin
                        win = 0;
                        sel = '0;
                    end
                end else if (ers > 0) begin
                    if (hd[0] == 8'hb0 && !susp && spend == 0)
                        spend = SUSP_CYC;
                    else if (susp && hd[0] == 8'h30)
                        susp = 1'b0;
                end else if (byp) begin
                    if (pgm)
                        mem[int'(addr)] = dq_wr;
                    else if (hd[1] == 8'h90 && hd[0] == 8'h00)
                        byp = 1'b0;
                    pgm = !pgm && hd[0] == 8'ha0;
                end else if (six() && ha[0] == 11'h555 && hd[0] == 8'h10) begin
                    chip = 1'b1;
                    ers = ERASE_CYC;
                end else if (six() && hd[0] == 8'h30) begin
                    win = WIN_CYC;
                    tmo = 1'b0;
                    sel[addr[18:12]] = 1'b1;
                end else if (ha[2] == 11'h555 && hd[2] == 8'haa && hd[1] == 8'h55
                             && hd[0] == 8'h20)
                    byp = 1'b1;
            end
            if (!oe_n && oe_q)
                tgl = !tgl;
            we_q = we_n;
            oe_q = oe_n;
            bsy = (ers > 0 || win > 0 || spend > 0) && !susp;
            rdy <= !bsy;
            if (oe_n || ce_n)
                dq_rd <= ~dq_rd; // released bus keeps moving
            else if (bsy)
                dq_rd <= {9'h000, tgl, 2'b00, tmo, tgl, 2'b00};
            else if (susp && sel[addr[18:12]])
                dq_rd <= {8'h00, 1'b1, 3'b000, 1'b1, tgl, 2'b00};
            else
                dq_rd <= mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hffff;
        end
    end
endmodule

// ===== flash_erase_bypass_sequencer_tb.sv
// bench for the flash host controller, driven over its register bus
// assumes the flash model above on the pins and one 25 MHz clock
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module flash_erase_bypass_sequencer_tb;
    import flash_seq_pkg::*;
    typedef logic [34:0] wr_t;
    typedef wr_t wq_t[$];
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, st, v;
    logic [18:0] f_addr, pa, sa;
    logic [15:0] f_dq_out, f_dq_in, pd, x, x0;
    logic        f_dq_oe, f_ce_n, f_we_n, f_oe_n, ready_busy_n, we_q = 1;
    int          errors = 0, n_tests = 0, cyc = 0, el, t_wr = 0;
    wq_t         got;
    assign hready = hreadyout;
    flash_seq_host flash_seq_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .f_addr, .f_dq_out,
        .f_dq_oe, .f_dq_in, .f_ce_n, .f_we_n, .f_oe_n, .ready_busy_n);
    flash_dev_model flash_dev_model_i (.clk(hclk), .rst_n(hresetn), .addr(f_addr),
        .dq_wr(f_dq_out), .ce_n(f_ce_n), .we_n(f_we_n), .oe_n(f_oe_n), .dq_rd(f_dq_in),
        .rdy(ready_busy_n));
    // clock
    initial begin
        forever #20 hclk = ~hclk;
    end
    // write-cycle monitor and run limit
    always @(posedge hclk) begin
        if (!we_q && f_we_n && !f_ce_n) begin
            got.push_back({f_addr, f_dq_out});
            t_wr <= cyc; // edge of the last write strobe rise
        end
        we_q <= f_we_n;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            final_report;
        end
    end
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one single word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // write cycles expected on the pins for an operation
    function automatic wq_t seq_of(input logic [3:0] op, input logic [18:0] a,
                                   input logic [15:0] d);
        wr_t u1 = {ADDR_UNLK1, CMD_UNLK1};
        wr_t u2 = {ADDR_UNLK2, CMD_UNLK2};
        wr_t s = {a[18:12], 12'h000, CMD_SECT};
        case (op)
            OP_BYP_EN:   return '{u1, u2, {ADDR_UNLK1, CMD_BYPASS}};
            OP_BPROG:    return '{{ADDR_DC, CMD_PROG}, {a, d}};
            OP_BYP_EXIT: return '{{ADDR_DC, CMD_BEXIT1}, {ADDR_DC, CMD_BEXIT2}};
            OP_CHIP:     return '{u1, u2, {ADDR_UNLK1, CMD_SETUP}, u1, u2, {ADDR_UNLK1, CMD_CHIP}};
            OP_SECT:     return '{u1, u2, {ADDR_UNLK1, CMD_SETUP}, u1, u2, s};
            OP_ADD_SECT: return '{s};
            OP_SUSP:     return '{{ADDR_DC, CMD_SUSP}};
            OP_RESUME:   return '{{ADDR_DC, CMD_RESUME}};
            default:     return {};
        endcase
    endfunction
    // start an operation, wait for idle, compare pin cycles and error flag
    task automatic run(input logic [3:0] op, input logic [18:0] a, input logic [15:0] d,
                       input logic bad);
        wq_t e;
        int  i = 0;
        bus(1'b1, REG_ADDR, {13'h0000, a}, v);
        bus(1'b1, REG_DATA, {16'h0000, d}, v);
        got.delete();
        bus(1'b1, REG_CTRL, {28'h0000000, op}, v);
        do begin
            bus(1'b0, REG_STATUS, 32'h0, st);
            i++;
        end while (st[ST_BUSY] !== 1'b0 && i < 100);
        if (!bad)
            e = seq_of(op, a, d);
        `CHK("n_writes", e.size(), got.size())
        foreach (e[k]) `CHK("write", e[k], got[k])
        `CHK("err", bad, st[ST_ERR])
        bus(1'b1, REG_STATUS, 32'h40, v); // clear error flag
    endtask
    // read one flash word through the controller
    task automatic rdw(input logic [18:0] a, output logic [15:0] r);
        run(OP_READ, a, 16'h0000, 1'b0);
        bus(1'b0, REG_RDATA, 32'h0, v);
        r = v[15:0];
    endtask
    // poll a status bit until it drops; el counts from the last write strobe
    task automatic wait_st(input int b);
        int t0 = cyc;
        do bus(1'b0, REG_STATUS, 32'h0, st); while (st[b] !== 1'b0 && cyc - t0 < 6000);
        el = cyc - t_wr;
    endtask
    // main sequence
    initial begin
        void'($urandom(32'hb7a925a5));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK("ce_idle", 1'b1, f_ce_n)
        bus(1'b1, 8'h20, 32'hffffffff, v); // unmapped write
        for (int r = 0; r < 9; r++) begin
            bus(1'b0, 8'(r * 4), 32'h0, v);
            `CHK("reset_reg", (r == 3) ? (32'h1 << ST_RDYBSY) : (r == 0) ? {28'h0000000, OP_READ} : 32'h0, v)
        end
        run(OP_BYP_EN, 19'h0, 16'h0, 1'b0);
        `CHK("bypass", 1'b1, st[ST_BYPASS])
        for (int k = 0; k < 4; k++) begin
            pa = 19'($urandom);
            pd = 16'($urandom);
            run(OP_BPROG, pa, pd, 1'b0);
            rdw(pa, x);
            `CHK("prog_rd", pd, x)
        end
        run(OP_CHIP, 19'h0, 16'h0, 1'b1);
        run(OP_BYP_EXIT, 19'h0, 16'h0, 1'b0);
        `CHK("bypass", 1'b0, st[ST_BYPASS])
        sa = pa ^ 19'h01000;
        run(OP_SECT, sa, 16'h0, 1'b0);
        `CHK("window", 1'b1, st[ST_WINDOW])
        run(OP_ADD_SECT, sa ^ 19'h20000, 16'h0, 1'b0);
        run(OP_BYP_EN, 19'h0, 16'h0, 1'b1);
        wait_st(ST_WINDOW);
        `CHK("window_len", 1'b1, el >= COLLECT_CYC && el <= COLLECT_CYC + 4)
        rdw(sa, x);
        bus(1'b0, REG_STATUS, 32'h0, st);
        `CHK("timer_flag", 1'b1, st[ST_TIMER])
        `CHK("poll_bit", 1'b0, st[ST_POLL])
        x0 = x;
        rdw(sa, x);
        `CHK("toggle", ~x0[6], x[6])
        run(OP_SUSP, 19'h0, 16'h0, 1'b0);
        `CHK("susp", 1'b1, st[ST_SUSP])
        // wait out the suspend latency before reading array data
        do bus(1'b0, REG_STATUS, 32'h0, st); while (st[ST_RDYBSY] !== 1'b1);
        rdw(pa, x);
        `CHK("susp_rd", pd, x)
        run(OP_RESUME, 19'h0, 16'h0, 1'b0);
        run(OP_RESUME, 19'h0, 16'h0, 1'b1);
        wait_st(ST_ERASE);
        `CHK("erase_end", 1'b1, st[ST_RDYBSY])
        run(OP_SECT, sa, 16'h0, 1'b0);
        run(OP_SUSP, 19'h0, 16'h0, 1'b0);
        `CHK("win_closed", 2'b01, {st[ST_WINDOW], st[ST_SUSP]})
        run(OP_RESUME, 19'h0, 16'h0, 1'b0);
        wait_st(ST_ERASE);
        `CHK("erase_end", 1'b0, st[ST_ERASE])
        run(OP_CHIP, 19'h0, 16'h0, 1'b0);
        `CHK("chip", 1'b1, st[ST_CHIP])
        run(OP_SUSP, 19'h0, 16'h0, 1'b1);
        wait_st(ST_CHIP);
        `CHK("chip_end", 1'b1, st[ST_RDYBSY])
        final_report;
    end
endmodule
